//--- design/timer_capture_defines.svh
`ifndef TIMER_CAPTURE_DEFINES_SVH
`define TIMER_CAPTURE_DEFINES_SVH

`define OFS_CONTROL_A 8'h00
`define OFS_CONTROL_B 8'h04
`define OFS_EVENT_CTRL 8'h08
`define OFS_INT_FLAGS 8'h0c
`define OFS_STATUS 8'h10
`define OFS_SYNC_BUSY 8'h14
`define OFS_FAULT_CTRL 8'h18
`define OFS_DRIVER_CTRL 8'h1c
`define OFS_TOP 8'h20
`define OFS_COUNT 8'h24
`define OFS_CC_BASE 8'h40

`define CA_SOFTWARE_RESET 0
`define CA_ENABLE 1
`define CA_ONESHOT 2
`define CA_CPTEN 8
`define CB_DIR 0
`define CB_DUAL 1
`define EV_ACT 0
`define EV_INV 4
`define EV_EN 5
`define IF_MC 0
`define IF_ERR 8
`define IF_FAULT 9
`define IF_OVF 10
`define ST_STOP 0
`define SB_SOFTWARE_RESET 0
`define SB_ENABLE 1
`define SB_CONTROL_B 2
`define SB_CC 8
`define FC_ACT 0
`define FC_HALT 8
`define FC_CAPTURE_CHANNEL_SELECT 10
`define DC_NRE 0
`define DC_NRV 8

`define SYNC_CYCLES 2'd2
`define TOP_RESET 16'hffff

`endif

//--- design/timer_capture_pkg.sv
package timer_capture_pkg;

	typedef enum logic [2:0] {
		EV_OFF = 3'h0,
		EV_PERIOD_PULSE = 3'h1,
		EV_PULSE_PERIOD = 3'h2
	} event1_action_t;

	typedef enum logic [2:0] {
		FA_DISABLE = 3'h0,
		FA_CAPTURE_EVERY = 3'h1,
		FA_CAPTURE_MINIMUM = 3'h2,
		FA_CAPTURE_MAXIMUM = 3'h3,
		FA_LOCAL_MINIMUM = 3'h4,
		FA_LOCAL_MAXIMUM = 3'h5,
		FA_LOCAL_EXTREMUM = 3'h6
	} fault_action_t;

	typedef enum logic [1:0] {
		HALT_NONE = 2'h0,
		HALT_HW = 2'h1,
		HALT_SW = 2'h2,
		HALT_NONREC = 2'h3
	} fault_halt_t;

endpackage : timer_capture_pkg

//--- design/timer_capture_fault_unit.sv
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "timer_capture_defines.svh"

module timer_capture_fault_unit
	import timer_capture_pkg::*;
#(
	parameter int CNT_W = 16,
	parameter int NUM_CH = 4
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Event and fault inputs
	input wire logic event1_in,
	input wire logic fault_in,
	// Waveform outputs
	output logic [NUM_CH-1:0] wave_out
);

	initial begin
		if (CNT_W < 2 || CNT_W > 32 || NUM_CH < 2 || NUM_CH > 4) begin
			$error("timer_capture_fault_unit: unsupported parameters");
		end
	end

	localparam logic [CNT_W-1:0] HALF_MAX = {1'b0, {(CNT_W-1){1'b1}}};

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (wd & m);
	endfunction : merge

	////////////////////////////////////////////////////////////////////
	// State

	logic ack_q;
	logic [31:0] rdata_q;
	logic en_q, oneshot_q, dir_q, dual_q;
	logic [NUM_CH-1:0] cpten_q, mc_q, nre_q, nrv_q, wave_q;
	event1_action_t evact_q;
	logic evinv_q, evin_en_q;
	logic err_q, fault_flag_q, ovf_q, stop_q;
	fault_action_t fact_q;
	fault_halt_t halt_q;
	logic [1:0] capture_channel_select_q;
	logic [CNT_W-1:0] top_q, count_q;
	logic [CNT_W-1:0] cc_q [NUM_CH];
	logic trend_dn_q;
	logic ev_s1_q, ev_s2_q, ev_s3_q, f_s1_q, f_s2_q, f_s3_q;
	logic [6:0] busy_q;
	logic [1:0] busy_cnt_q [7];
	logic soft_rst_q;

	////////////////////////////////////////////////////////////////////
	// Bus slave: one wait cycle per access, then the answer

	logic req, wr_fire;
	logic [31:0] wdat;
	logic [NUM_CH-1:0] cc_wr;
	logic [31:0] rd_mux;
	logic [31:0] cur;

	assign req = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = req & ~ack_q;
	assign wr_fire = avs_write_in & ack_q;
	assign avs_readdata_out = rdata_q;

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (avs_address_in)
			`OFS_CONTROL_A: begin
				rd_mux[`CA_ENABLE] = en_q;
				rd_mux[`CA_ONESHOT] = oneshot_q;
				rd_mux[`CA_CPTEN +: NUM_CH] = cpten_q;
			end
			`OFS_CONTROL_B: begin
				rd_mux[`CB_DIR] = dir_q;
				rd_mux[`CB_DUAL] = dual_q;
			end
			`OFS_EVENT_CTRL: begin
				rd_mux[`EV_ACT +: 3] = evact_q;
				rd_mux[`EV_INV] = evinv_q;
				rd_mux[`EV_EN] = evin_en_q;
			end
			`OFS_INT_FLAGS: begin
				rd_mux[`IF_MC +: NUM_CH] = mc_q;
				rd_mux[`IF_ERR] = err_q;
				rd_mux[`IF_FAULT] = fault_flag_q;
				rd_mux[`IF_OVF] = ovf_q;
			end
			`OFS_STATUS: rd_mux[`ST_STOP] = stop_q;
			`OFS_SYNC_BUSY: begin
				rd_mux[`SB_SOFTWARE_RESET] = busy_q[0];
				rd_mux[`SB_ENABLE] = busy_q[1];
				rd_mux[`SB_CONTROL_B] = busy_q[2];
				rd_mux[`SB_CC +: NUM_CH] = busy_q[3 +: NUM_CH];
			end
			`OFS_FAULT_CTRL: begin
				rd_mux[`FC_ACT +: 3] = fact_q;
				rd_mux[`FC_HALT +: 2] = halt_q;
				rd_mux[`FC_CAPTURE_CHANNEL_SELECT +: 2] = capture_channel_select_q;
			end
			`OFS_DRIVER_CTRL: begin
				rd_mux[`DC_NRE +: NUM_CH] = nre_q;
				rd_mux[`DC_NRV +: NUM_CH] = nrv_q;
			end
			`OFS_TOP: rd_mux[CNT_W-1:0] = top_q;
			`OFS_COUNT: rd_mux[CNT_W-1:0] = count_q;
			default: begin
				for (int i = 0; i < NUM_CH; i++) begin
					if (avs_address_in == `OFS_CC_BASE + 8'(4 * i)) begin
						rd_mux[CNT_W-1:0] = cc_q[i];
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read_in && !ack_q) begin
			rdata_q <= rd_mux;
		end
	end

	// Partial writes reuse the current read value in untouched lanes, so set interrupt flags in those lanes clear
	assign cur = rd_mux;
	assign wdat = merge(cur, avs_writedata_in, avs_byteenable_in);

	////////////////////////////////////////////////////////////////////
	// Configuration registers

	logic wr_ca, wr_cb, wr_ev, wr_fc, wr_dc, wr_top, wr_if;
	assign wr_ca = wr_fire && avs_address_in == `OFS_CONTROL_A;
	assign wr_cb = wr_fire && avs_address_in == `OFS_CONTROL_B;
	assign wr_ev = wr_fire && avs_address_in == `OFS_EVENT_CTRL;
	assign wr_fc = wr_fire && avs_address_in == `OFS_FAULT_CTRL;
	assign wr_dc = wr_fire && avs_address_in == `OFS_DRIVER_CTRL;
	assign wr_top = wr_fire && avs_address_in == `OFS_TOP;
	assign wr_if = wr_fire && avs_address_in == `OFS_INT_FLAGS;

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in || soft_rst_q) begin
			en_q <= 1'b0;
			oneshot_q <= 1'b0;
			cpten_q <= '0;
			evact_q <= EV_OFF;
			evinv_q <= 1'b0;
			evin_en_q <= 1'b0;
			fact_q <= FA_DISABLE;
			halt_q <= HALT_NONE;
			capture_channel_select_q <= 2'h0;
			nre_q <= '0;
			nrv_q <= '0;
			top_q <= CNT_W'(`TOP_RESET);
		end else begin
			if (wr_ca) begin
				en_q <= wdat[`CA_ENABLE];
				oneshot_q <= wdat[`CA_ONESHOT];
				cpten_q <= wdat[`CA_CPTEN +: NUM_CH];
			end
			if (wr_ev) begin
				evact_q <= event1_action_t'(wdat[`EV_ACT +: 3]);
				evinv_q <= wdat[`EV_INV];
				evin_en_q <= wdat[`EV_EN];
			end
			if (wr_fc) begin
				fact_q <= fault_action_t'(wdat[`FC_ACT +: 3]);
				halt_q <= fault_halt_t'(wdat[`FC_HALT +: 2]);
				capture_channel_select_q <= wdat[`FC_CAPTURE_CHANNEL_SELECT +: 2];
			end
			if (wr_dc) begin
				nre_q <= wdat[`DC_NRE +: NUM_CH];
				nrv_q <= wdat[`DC_NRV +: NUM_CH];
			end
			if (wr_top) begin
				top_q <= wdat[CNT_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Synchronization busy flags

	logic [6:0] sync_start;
	assign sync_start[0] = wr_ca && wdat[`CA_SOFTWARE_RESET];
	assign sync_start[1] = wr_ca;
	assign sync_start[2] = wr_cb;
	// Busy positions of absent channels never rise
	if (NUM_CH < 4) begin : g_busy_pad
		assign sync_start[6:3 + NUM_CH] = '0;
	end
	assign sync_start[3 +: NUM_CH] = cc_wr;

	for (genvar k = 0; k < 7; k++) begin : g_busy
		always_ff @(posedge core_clk_in) begin
			if (!rst_b_in) begin
				busy_q[k] <= 1'b0;
				busy_cnt_q[k] <= 2'd0;
			end else if (sync_start[k]) begin
				busy_q[k] <= 1'b1;
				busy_cnt_q[k] <= 2'd0;
			end else if (busy_q[k]) begin
				busy_cnt_q[k] <= busy_cnt_q[k] + 2'd1;
				if (busy_cnt_q[k] == `SYNC_CYCLES) begin
					busy_q[k] <= 1'b0;
				end
			end
		end
	end

	// Software reset lands when its own synchronization completes
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			soft_rst_q <= 1'b0;
		end else begin
			soft_rst_q <= busy_q[0] && busy_cnt_q[0] == `SYNC_CYCLES;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Input synchronizers and edge detection

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			ev_s1_q <= 1'b0;
			ev_s2_q <= 1'b0;
			ev_s3_q <= 1'b0;
			f_s1_q <= 1'b0;
			f_s2_q <= 1'b0;
			f_s3_q <= 1'b0;
		end else begin
			ev_s1_q <= event1_in;
			ev_s2_q <= ev_s1_q;
			ev_s3_q <= ev_s2_q;
			f_s1_q <= fault_in;
			f_s2_q <= f_s1_q;
			f_s3_q <= f_s2_q;
		end
	end

	logic ev_on, ev_rise, ev_fall, ev_wrap, ev_pulse, fault_edge;
	assign ev_on = evin_en_q && evact_q != EV_OFF && en_q;
	assign ev_rise = ev_s2_q & ~ev_s3_q;
	assign ev_fall = ~ev_s2_q & ev_s3_q;
	assign ev_wrap = ev_on && (evinv_q ? ev_fall : ev_rise);
	assign ev_pulse = ev_on && (evinv_q ? ev_rise : ev_fall);
	assign fault_edge = f_s2_q & ~f_s3_q && fact_q != FA_DISABLE;

	////////////////////////////////////////////////////////////////////
	// Counter, one-shot and halt

	logic halted, ovf_evt, running;
	assign halted = (halt_q == HALT_HW && f_s2_q) ||
		(halt_q == HALT_SW && fault_flag_q);
	assign running = en_q && !stop_q && !halted;
	assign ovf_evt = running && !ev_wrap &&
		(dir_q ? count_q == '0 : count_q == top_q);

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in || soft_rst_q) begin
			count_q <= '0;
			dir_q <= 1'b0;
			dual_q <= 1'b0;
		end else begin
			if (wr_cb) begin
				dir_q <= wdat[`CB_DIR];
				dual_q <= wdat[`CB_DUAL];
			end else if (running && ev_wrap) begin
				count_q <= dir_q ? top_q : '0;
			end else if (running && dual_q) begin
				if (ovf_evt) begin
					dir_q <= ~dir_q;
					count_q <= dir_q ? count_q + 1'b1 : count_q - 1'b1;
				end else begin
					count_q <= dir_q ? count_q - 1'b1 : count_q + 1'b1;
				end
			end else if (running) begin
				if (ovf_evt) begin
					count_q <= dir_q ? top_q : '0;
				end else begin
					count_q <= dir_q ? count_q - 1'b1 : count_q + 1'b1;
				end
			end
		end
	end

	// A one-shot stop holds until software rewrites control A with enable or a software reset lands
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in || soft_rst_q) begin
			stop_q <= 1'b0;
		end else if (ovf_evt && oneshot_q) begin
			stop_q <= 1'b1;
		end else if (wr_ca && wdat[`CA_ENABLE]) begin
			stop_q <= 1'b0;
		end
	end

	logic safe_out;
	assign safe_out = stop_q || (halt_q == HALT_NONREC && f_s2_q);

	for (genvar i = 0; i < NUM_CH; i++) begin : g_wave
		always_ff @(posedge core_clk_in) begin
			if (!rst_b_in || soft_rst_q) begin
				wave_q[i] <= 1'b0;
			end else if (safe_out && nre_q[i]) begin
				wave_q[i] <= nrv_q[i];
			end else if (!safe_out) begin
				wave_q[i] <= count_q < cc_q[i];
			end
		end
	end
	assign wave_out = wave_q;

	////////////////////////////////////////////////////////////////////
	// Capture decisions

	logic [CNT_W-1:0] cap_val, last_val;
	logic [1:0] per_ch, pw_ch;
	logic f_lower, f_higher, f_store, f_flag, f_local_minimum, f_local_maximum;

	// In dual-slope mode the ramp direction replaces the MSB when top is below HALF_MAX
	assign cap_val = (dual_q && top_q < HALF_MAX) ?
		{dir_q, count_q[CNT_W-2:0]} : count_q;

	assign per_ch = (evact_q == EV_PULSE_PERIOD) ? 2'd1 : 2'd0;
	assign pw_ch = (evact_q == EV_PULSE_PERIOD) ? 2'd0 : 2'd1;

	assign last_val = cc_q[capture_channel_select_q];
	// With cleared capture values, up-counting never finds anything lower
	assign f_lower = cap_val < last_val;
	assign f_higher = cap_val > last_val;
	assign f_local_minimum = f_higher && trend_dn_q;
	assign f_local_maximum = f_lower && !trend_dn_q;

	always_comb begin
		f_store = 1'b0;
		f_flag = 1'b0;
		if (fault_edge) begin
			unique case (fact_q)
				FA_CAPTURE_EVERY: begin
					f_store = 1'b1;
					f_flag = 1'b1;
				end
				FA_CAPTURE_MINIMUM: begin
					f_store = f_lower;
					f_flag = f_lower;
				end
				FA_CAPTURE_MAXIMUM: begin
					f_store = f_higher;
					f_flag = f_higher;
				end
				FA_LOCAL_MINIMUM: begin
					f_store = 1'b1;
					f_flag = f_local_minimum;
				end
				FA_LOCAL_MAXIMUM: begin
					f_store = 1'b1;
					f_flag = f_local_maximum;
				end
				FA_LOCAL_EXTREMUM: begin
					f_store = 1'b1;
					f_flag = f_local_minimum || f_local_maximum;
				end
				default: begin
					f_store = 1'b0;
					f_flag = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in || soft_rst_q) begin
			trend_dn_q <= 1'b0;
		end else if (f_store && cap_val != last_val) begin
			trend_dn_q <= f_lower;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Channels

	logic [NUM_CH-1:0] cap_req, cap_ok, cap_err;

	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		assign cap_req[i] = (ev_wrap && per_ch == 2'(i)) ||
			(ev_pulse && pw_ch == 2'(i)) ||
			(f_store && capture_channel_select_q == 2'(i));
		assign cap_ok[i] = cap_req[i] && cpten_q[i] && !mc_q[i];
		assign cap_err[i] = cap_req[i] && cpten_q[i] && mc_q[i];
		assign cc_wr[i] = wr_fire &&
			avs_address_in == `OFS_CC_BASE + 8'(4 * i);

		always_ff @(posedge core_clk_in) begin
			if (!rst_b_in || soft_rst_q) begin
				cc_q[i] <= '0;
			end else if (cap_ok[i]) begin
				cc_q[i] <= cap_val;
			end else if (cc_wr[i]) begin
				cc_q[i] <= wdat[CNT_W-1:0];
			end
		end

		// Hardware set wins over a same-cycle clear
		always_ff @(posedge core_clk_in) begin
			if (!rst_b_in || soft_rst_q) begin
				mc_q[i] <= 1'b0;
			end else if (cap_ok[i]) begin
				mc_q[i] <= 1'b1;
			end else if (wr_if && wdat[`IF_MC + i]) begin
				mc_q[i] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Shared interrupt flags, write one to clear, set wins

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in || soft_rst_q) begin
			err_q <= 1'b0;
			fault_flag_q <= 1'b0;
			ovf_q <= 1'b0;
		end else begin
			if (|cap_err) begin
				err_q <= 1'b1;
			end else if (wr_if && wdat[`IF_ERR]) begin
				err_q <= 1'b0;
			end
			if (f_flag) begin
				fault_flag_q <= 1'b1;
			end else if (wr_if && wdat[`IF_FAULT]) begin
				fault_flag_q <= 1'b0;
			end
			if (ovf_evt) begin
				ovf_q <= 1'b1;
			end else if (wr_if && wdat[`IF_OVF]) begin
				ovf_q <= 1'b0;
			end
		end
	end

endmodule : timer_capture_fault_unit

`default_nettype wire

//--- tb/timer_capture_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer_capture_defines.svh"

module timer_capture_asserts #(
	parameter int NUM_CH = 4
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// Bus
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	// Pins
	input wire logic event1_in,
	input wire logic fault_in,
	input wire logic [NUM_CH-1:0] wave_out
);
	localparam logic [31:0] CH_MASK = (32'h1 << NUM_CH) - 32'h1;
	localparam logic [31:0] BUSY_OK = 32'h7 | (CH_MASK << 8);
	localparam logic [31:0] FLAG_OK = 32'h700 | CH_MASK;
	logic req;
	logic take;
	logic [3:0] quiet_q;

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_b_in);

	assign req = avs_read_in | avs_write_in;
	// Read data is latched at this edge and stands from the next one
	assign take = avs_read_in & avs_waitrequest_out;

	// Busy flags can only be up shortly after a register write
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			quiet_q <= 4'h0;
		end else if (avs_write_in && !avs_waitrequest_out) begin
			quiet_q <= 4'h0;
		end else if (quiet_q != 4'hf) begin
			quiet_q <= quiet_q + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	chk_idle_no_wait: assert property (!req |-> !avs_waitrequest_out)
		else $error("waitrequest raised with no request");
	chk_first_wait: assert property (req && !$past(req) |-> avs_waitrequest_out)
		else $error("new request answered without a wait cycle");
	chk_one_wait: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("request held more than one wait cycle");
	chk_rdata_hold: assert property (!take |=> $stable(avs_readdata_out))
		else $error("read data changed without a read");
	chk_unmapped_zero: assert property (take && avs_address_in == 8'h30
		|=> avs_readdata_out == 32'h0)
		else $error("unmapped read returned nonzero");
	chk_busy_map: assert property (take && avs_address_in == `OFS_SYNC_BUSY |=> (avs_readdata_out & ~BUSY_OK) == 32'h0)
		else $error("busy bit set outside implemented positions");
	chk_busy_clear: assert property (take && avs_address_in == `OFS_SYNC_BUSY && quiet_q >= 4'h8 |=> avs_readdata_out == 32'h0)
		else $error("busy flag stuck after synchronization");
	chk_status_bits: assert property (take && avs_address_in == `OFS_STATUS |=> avs_readdata_out[31:1] == 31'h0)
		else $error("status reserved bits set");
	chk_flag_bits: assert property (take && avs_address_in == `OFS_INT_FLAGS |=> (avs_readdata_out & ~FLAG_OK) == 32'h0)
		else $error("interrupt flag outside defined bits");

	cover property (take && avs_address_in == `OFS_SYNC_BUSY && quiet_q < 4'h4);
	cover property ($rose(fault_in));
	cover property ($fell(event1_in));
endmodule : timer_capture_asserts
`default_nettype wire

//--- tb/event_source.sv
`timescale 1ns/100ps
`default_nettype none

module event_source (
	// Clock
	input wire logic core_clk_in,
	// Event lines
	output logic event1_out,
	output logic fault_out
);
	initial begin
		event1_out = 1'b0;
		fault_out = 1'b0;
	end

	// Called right after a clock edge; levels last whole cycles
	task automatic hold_event(input logic lvl, input int n);
		event1_out <= lvl;
		repeat (n) @(posedge core_clk_in);
	endtask : hold_event

	task automatic pulse_fault(input int n);
		fault_out <= 1'b1;
		repeat (n) @(posedge core_clk_in);
		fault_out <= 1'b0;
		repeat (n) @(posedge core_clk_in);
	endtask : pulse_fault
endmodule : event_source
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer_capture_defines.svh"

module tb
	import timer_capture_pkg::*;
;
	logic core_clk_in, rst_b_in, avs_read_in, avs_write_in;
	logic [7:0] avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, q, p1, w1, p2, w2, p, w;
	logic [3:0] avs_byteenable_in, wave_out;
	logic avs_waitrequest_out, event1_in, fault_in;
	logic [63:0] exp_q[$];
	logic [63:0] ent;
	logic [31:0] ftab[9] = '{32'h00555500, 32'h12555511, 32'h23000000,
		32'h21ffff11, 32'h30ffff00, 32'h33000011, 32'h4155551f,
		32'h5255551f, 32'h6055551f};
	logic [31:0] e, fx, fm;
	logic [7:0] ca;
	int bad_count, n_tests, h1, l1, n;
	integer seed;

	timer_capture_fault_unit #(.CNT_W(16), .NUM_CH(4)) timer_capture_fault_unit_i (
		.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out),
		.event1_in(event1_in), .fault_in(fault_in), .wave_out(wave_out));
	event_source ev_i (.core_clk_in(core_clk_in), .event1_out(event1_in),
		.fault_out(fault_in));

	initial core_clk_in = 1'b0;
	always #25 core_clk_in = ~core_clk_in;

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check

	// Request held until waitrequest is sampled low, then released for a cycle
	task automatic access(input logic rd, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int k;
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_read_in <= rd;
		avs_write_in <= !rd;
		k = 0;
		do begin
			@(posedge core_clk_in);
			k++;
		end while (avs_waitrequest_out !== 1'b0 && k < 50);
		if (k >= 50) begin
			bad_count++;
			print_verdict();
		end
		r = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		@(posedge core_clk_in);
	endtask : access

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		access(1'b0, a, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic [31:0] m);
		logic [31:0] r;
		exp_q.push_back({x, m});
		access(1'b1, a, 32'h0, r);
	endtask : rd

	task automatic rdv(input logic [7:0] a, output logic [31:0] r);
		exp_q.push_back(64'h0);
		access(1'b1, a, 32'h0, r);
	endtask : rdv

	task automatic busy_seen(input logic [7:0] a, input logic [31:0] d,
		input int b);
		logic [31:0] r;
		logic s;
		s = 1'b0;
		wr(a, d);
		repeat (3) begin
			rdv(`OFS_SYNC_BUSY, r);
			s = s | r[b];
		end
		check({31'h0, s}, 32'h1);
		repeat (8) @(posedge core_clk_in);
		rd(`OFS_SYNC_BUSY, 32'h0, 32'hffffffff);
	endtask : busy_seen

	// Flags cleared mid-cycle so the second cycle's captures are stored
	task automatic measure(input int h, input int l, output logic [31:0] pv,
		output logic [31:0] wv);
		ev_i.hold_event(1'b1, h);
		fork
			ev_i.hold_event(1'b0, l);
			begin
				repeat (10) @(posedge core_clk_in);
				wr(`OFS_INT_FLAGS, 32'h70f);
			end
		join
		ev_i.hold_event(1'b1, h);
		ev_i.hold_event(1'b0, l);
		rdv(`OFS_CC_BASE, pv);
		rdv(`OFS_CC_BASE + 8'h04, wv);
	endtask : measure

	always @(posedge core_clk_in) begin
		if (rst_b_in === 1'b1 && avs_read_in === 1'b1
			&& avs_waitrequest_out === 1'b0 && exp_q.size() > 0) begin
			ent = exp_q.pop_front();
			if (ent[31:0] != 32'h0) begin
				check(avs_readdata_out & ent[31:0], ent[63:32] & ent[31:0]);
			end
		end
	end

	initial begin
		repeat (100000) @(posedge core_clk_in);
		bad_count++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'he7d9;
		rst_b_in = 1'b0;
		avs_address_in = 8'h0;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_writedata_in = 32'h0;
		avs_byteenable_in = 4'hf;
		repeat (12) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		@(posedge core_clk_in);
		rd(`OFS_SYNC_BUSY, 32'h0, 32'hffffffff);
		rd(`OFS_TOP, 32'hffff, 32'hffffffff);
		wr(8'h30, 32'hffffffff);
		rd(8'h30, 32'h0, 32'hffffffff);
		busy_seen(`OFS_CONTROL_B, 32'h0, 2);
		busy_seen(`OFS_CONTROL_A, 32'h302, 1);
		busy_seen(`OFS_CC_BASE + 8'h08, 32'h0, 10);
		// Event measurement, both orders and inverted
		h1 = 30 + ($random(seed) & 15);
		l1 = 30 + ($random(seed) & 15);
		wr(`OFS_EVENT_CTRL, 32'h21);
		measure(h1, l1, p1, w1);
		rd(`OFS_INT_FLAGS, 32'h3, 32'h103);
		measure(h1 + 5, l1 + 2, p2, w2);
		check(p2 - p1, 32'h7);
		check(w2 - w1, 32'h5);
		ev_i.hold_event(1'b1, h1);
		ev_i.hold_event(1'b0, l1);
		rd(`OFS_INT_FLAGS, 32'h103, 32'h103);
		rd(`OFS_CC_BASE, p2, 32'hffff);
		wr(`OFS_EVENT_CTRL, 32'h22);
		measure(h1 + 5, l1 + 2, p, w);
		check(p, w2);
		check(w, p2);
		wr(`OFS_EVENT_CTRL, 32'h31);
		measure(h1, l1, p, w);
		check(p, p1);
		check(w - l1, w1 - h1);
		q = {16'h0, 16'($random(seed))};
		wr(`OFS_CC_BASE + 8'h04, q);
		wr(`OFS_CONTROL_A, 32'h102);
		wr(`OFS_EVENT_CTRL, 32'h21);
		measure(h1, l1, p, w);
		check(w, q);
		rd(`OFS_INT_FLAGS, 32'h1, 32'h3);
		// Fault capture modes over a short counter range
		wr(`OFS_EVENT_CTRL, 32'h0);
		wr(`OFS_TOP, 32'hfff);
		wr(`OFS_CONTROL_A, 32'hf02);
		foreach (ftab[i]) begin
			e = ftab[i];
			ca = `OFS_CC_BASE + {4'h0, e[25:24], 2'b00};
			wr(`OFS_FAULT_CTRL, {20'h0, e[25:24], 2'b00, 5'h0, e[30:28]});
			wr(ca, {16'h0, e[23:8]});
			wr(`OFS_INT_FLAGS, 32'h70f);
			ev_i.pulse_fault(10);
			rdv(ca, q);
			check({31'h0, q[15:0] !== e[23:8]}, {31'h0, e[4]});
			fx = ({31'h0, e[0]} << 9) | ({31'h0, e[4]} << e[25:24]);
			fm = (e[3:0] == 4'hf ? 32'h0 : 32'h200) | (32'h1 << e[25:24]);
			rd(`OFS_INT_FLAGS, fx, fm);
		end
		// One-shot stop drives the safe pattern
		// Top stays at the short range so the count cannot sit above it
		wr(`OFS_TOP, 32'hfff);
		wr(`OFS_DRIVER_CTRL, 32'h50f);
		wr(`OFS_CONTROL_A, 32'h6);
		n = 0;
		q = 32'h0;
		while (q[0] !== 1'b1 && n < 2000) begin
			rdv(`OFS_STATUS, q);
			n++;
		end
		check(q, 32'h1);
		@(negedge core_clk_in);
		check({28'h0, wave_out}, 32'h5);
		@(posedge core_clk_in);
		rdv(`OFS_COUNT, p);
		repeat (20) @(posedge core_clk_in);
		rdv(`OFS_COUNT, w);
		check(w, p);
		wr(`OFS_EVENT_CTRL, 32'h21);
		busy_seen(`OFS_CONTROL_A, 32'h1, 0);
		rd(`OFS_EVENT_CTRL, 32'h0, 32'h3f);
		print_verdict();
	end
endmodule : tb

bind timer_capture_fault_unit timer_capture_asserts #(.NUM_CH(NUM_CH))
	timer_capture_asserts_i (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
	.avs_byteenable_in(avs_byteenable_in),
	.avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out), .event1_in(event1_in),
	.fault_in(fault_in), .wave_out(wave_out));
`default_nettype wire
